// ===== output_routing_pkg.sv
// Constants and types shared by the output routing block and its link transmitter
package output_routing_pkg;

  // Register offsets
  localparam logic [7:0] PAR_A_OFS  = 8'h1A;
  localparam logic [7:0] LNK_A_OFS  = 8'h1B;
  localparam logic [7:0] PAR_B_OFS  = 8'h1C;
  localparam logic [7:0] LNK_B_OFS  = 8'h1D;
  localparam logic [7:0] STATUS_OFS = 8'h20;

  // Values after reset
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] RDATA_RST  = 8'h00;

  // Field positions
  localparam int SRC_AGC_BIT    = 0;
  localparam int AGC_A_EN_BIT   = 1;
  localparam int AGC_B_EN_BIT   = 2;
  localparam int CHAN_EN_LSB    = 1;
  localparam int PAR_PACK_BIT   = 5;
  localparam int LNK_MODE_BIT   = 1;
  localparam int LNK_NOGAIN_BIT = 2;
  localparam int DLY_LSB        = 3;
  localparam int DLY_W          = 4;
  localparam int LINK_EN_BIT    = 7;

  // Counts
  localparam int NUM_CHAN   = 4;
  localparam int NUM_AGC    = 2;
  localparam int NUM_SRC    = 6;
  localparam int NUM_SIDE   = 2;
  localparam int QUAD_BYTES = 16;
  localparam logic [3:0] LINK_MIN_WAIT = 4'h6;
  localparam logic [3:0] LAST_BYTE     = 4'hF;

  // One source sample: I, Q and gain or RSSI word
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
    logic [15:0] gain;
  } src_word_t;

  // One quad-word handed to the link domain with its start delay
  typedef struct packed {
    logic [127:0]       data;
    logic [DLY_W-1:0]   delay;
  } quad_xfer_t;

  typedef enum logic [1:0] {LNK_IDLE, LNK_WAIT_RDY, LNK_DELAY, LNK_SEND} link_state_t;

endpackage

// ===== link_port_tx.sv
// Link port transmitter running on the link clock, one quad-word per handshake
`timescale 1ns/10ps
`default_nettype none
module link_port_tx
  import output_routing_pkg::*;
(
  // Link clock domain
  input  wire logic       link_clk_in,
  input  wire logic       link_rst_in,
  // Handshake from core domain
  input  wire quad_xfer_t xfer_in,
  input  wire logic       req_tgl_in,
  output logic            ack_tgl_out,
  // Link pins
  input  wire logic       rdy_in,
  output logic [7:0]      data_out,
  output logic            valid_out
);

  logic [2:0]  req_s_ff;
  logic [2:0]  rdy_s_ff;
  logic        req_seen_ff;
  logic        rdy_ok_ff;
  link_state_t state_ff;
  quad_xfer_t  buf_ff;
  logic [3:0]  cnt_ff;
  logic [3:0]  idx_ff;
  logic [3:0]  wait_cnt;

  // Never start sooner than the floor, whatever software programmed
  assign wait_cnt = (buf_ff.delay < LINK_MIN_WAIT) ? LINK_MIN_WAIT : buf_ff.delay;

  // Three-stage synchronisers; a change counts when stages two and three agree
  always_ff @(posedge link_clk_in) begin
    if (link_rst_in) begin
      req_s_ff    <= 3'h0;
      rdy_s_ff    <= 3'h0;
      req_seen_ff <= 1'b0;
      rdy_ok_ff   <= 1'b0;
    end else begin
      req_s_ff <= {req_s_ff[1:0], req_tgl_in};
      rdy_s_ff <= {rdy_s_ff[1:0], rdy_in};
      if (req_s_ff[1] == req_s_ff[2]) req_seen_ff <= req_s_ff[2];
      if (rdy_s_ff[1] == rdy_s_ff[2]) rdy_ok_ff <= rdy_s_ff[2];
    end
  end

  // Transfer sequencer: take quad, wait data ready, hold off, send sixteen bytes
  always_ff @(posedge link_clk_in) begin
    if (link_rst_in) begin
      state_ff    <= LNK_IDLE;
      buf_ff      <= '0;
      cnt_ff      <= 4'h0;
      idx_ff      <= 4'h0;
      ack_tgl_out <= 1'b0;
      data_out    <= 8'h00;
      valid_out   <= 1'b0;
    end else begin
      valid_out <= 1'b0;
      unique case (state_ff)
        LNK_IDLE: begin
          if (req_seen_ff != ack_tgl_out) begin
            buf_ff      <= xfer_in;    // Core holds data stable until the ack returns
            ack_tgl_out <= req_seen_ff;
            state_ff    <= LNK_WAIT_RDY;
          end
        end
        LNK_WAIT_RDY: begin
          if (rdy_ok_ff) begin
            cnt_ff   <= wait_cnt;
            state_ff <= LNK_DELAY;
          end
        end
        LNK_DELAY: begin
          cnt_ff <= cnt_ff - 4'h1;
          if (cnt_ff == 4'h1) begin
            idx_ff   <= 4'h0;
            state_ff <= LNK_SEND;
          end
        end
        LNK_SEND: begin
          data_out  <= buf_ff.data[{idx_ff, 3'h0} +: 8];
          valid_out <= 1'b1;
          idx_ff    <= idx_ff + 4'h1;
          if (idx_ff == LAST_BYTE) state_ff <= LNK_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== output_port_routing_control.sv
// Output routing for two sides, each a parallel port or a link port, fed by channels and AGCs
//
// Functional notes
// - Link control bit 7 set enables that side's link port, else the parallel port.
// - Parallel port of a side works only while its link enable bit is zero.
// - Parallel bit 0 picks channel data (bits 1-4) or AGC data (bits 1-2).
// - Parallel AGC mode: bit 1 allows AGC A, bit 2 allows AGC B.
// - Parallel channel mode: bits 1-4 choose which of four channels are output.
// - Parallel output serves pending sources lowest index first; source indicator names each word's origin.
// - Pack bit clear: 16-bit words, I then Q, IQ indicator marks which.
// - Pack bit set: 8-bit I and 8-bit Q together, IQ indicator high.
// - Link bit 0 picks channel data (format bit 1) or AGC data (bits 1-2).
// - Link channel mode: bit 1 clear alternates channels 0,1; set cycles 0-3.
// - Link AGC bit 1 set sends only own AGC IQ and gain; software clears bit 2.
// - Link AGC bit 1 clear alternates AGC A and B; bit 2 excludes gain.
// - Gain word is zero padded beside IQ to fill a 16-byte quad-word.
// - Gain exclusion bit is ignored when the link carries channel data.
// - Link bits 6-3 set delay from data ready to first transmitted byte.
// - Link waits at least six link clocks after data ready before sending.
`timescale 1ns/10ps
`default_nettype none
module output_port_routing_control
  import output_routing_pkg::*;
(
  // Core clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Link clock and its synchronous reset
  input  wire logic        link_clk_in,
  input  wire logic        link_rst_in,
  // Register port
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [7:0]       reg_rdata_out,
  // Channel filter and AGC sources
  input  wire src_word_t   chan_word_in [NUM_CHAN],
  input  wire logic [3:0]  chan_trig_in,
  input  wire src_word_t   agc_word_in [NUM_AGC],
  input  wire logic [1:0]  agc_trig_in,
  // Parallel ports, one per side
  output logic [15:0]      par_data_out [NUM_SIDE],
  output logic [1:0]       par_valid_out,
  output logic [1:0]       par_iq_out,
  output logic [2:0]       par_src_out [NUM_SIDE],
  // Link ports, one per side
  input  wire logic [1:0]  link_rdy_in,
  output logic [7:0]       link_data_out [NUM_SIDE],
  output logic [1:0]       link_valid_out
);

  logic [7:0]  par_ctrl_ff [NUM_SIDE];
  logic [7:0]  lnk_ctrl_ff [NUM_SIDE];
  src_word_t   src_ff [NUM_SRC];
  logic [5:0]  src_trig;
  logic [5:0]  pend_ff [NUM_SIDE];
  logic [5:0]  accept [NUM_SIDE];
  logic [5:0]  par_clr [NUM_SIDE];
  logic [5:0]  lnk_clr [NUM_SIDE];
  logic [1:0]  par_busy;
  logic [1:0]  xfer_open;

  assign src_trig = {agc_trig_in, chan_trig_in};

  // Register writes; control reaches the datapath the cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      par_ctrl_ff[0] <= CTRL_RST;
      par_ctrl_ff[1] <= CTRL_RST;
      lnk_ctrl_ff[0] <= CTRL_RST;
      lnk_ctrl_ff[1] <= CTRL_RST;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        PAR_A_OFS: par_ctrl_ff[0] <= {2'b00, reg_wdata_in[5:0]};
        LNK_A_OFS: lnk_ctrl_ff[0] <= reg_wdata_in;
        PAR_B_OFS: par_ctrl_ff[1] <= {2'b00, reg_wdata_in[5:0]};
        LNK_B_OFS: lnk_ctrl_ff[1] <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Register reads; unmapped offsets answer zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= RDATA_RST;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        PAR_A_OFS:  reg_rdata_out <= par_ctrl_ff[0];
        LNK_A_OFS:  reg_rdata_out <= lnk_ctrl_ff[0];
        PAR_B_OFS:  reg_rdata_out <= par_ctrl_ff[1];
        LNK_B_OFS:  reg_rdata_out <= lnk_ctrl_ff[1];
        STATUS_OFS: reg_rdata_out <= {2'b00, xfer_open, par_busy,
                                      |pend_ff[1], |pend_ff[0]};
        default:    reg_rdata_out <= RDATA_RST;
      endcase
    end else begin
      reg_rdata_out <= RDATA_RST;
    end
  end

  // Source samples are captured at their trigger so later triggers can queue
  genvar gs;
  generate
    for (gs = 0; gs < NUM_SRC; gs++) begin : g_src
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          src_ff[gs] <= '0;
        end else if (src_trig[gs]) begin
          src_ff[gs] <= (gs < NUM_CHAN) ? chan_word_in[gs % NUM_CHAN]
                                        : agc_word_in[gs % NUM_AGC];
        end
      end
    end
  endgenerate

  // Per-side routing: pending queue, parallel engine and link quad builder
  genvar gd;
  generate
    for (gd = 0; gd < NUM_SIDE; gd++) begin : g_side
      logic        link_en;
      logic        par_pack;
      logic        lnk_agc;
      logic        lnk_mode;
      logic        gain_incl;
      logic [2:0]  pick;
      logic        pick_ok;
      logic        pbusy_ff;
      logic [2:0]  psel_ff;
      logic [2:0]  lsrc;
      logic [1:0]  slot_ff;
      logic [1:0]  seq_ff;
      logic [1:0]  slot_last;
      logic        req_ff;
      logic [2:0]  ack_s_ff;
      logic        ack_ok_ff;
      quad_xfer_t  xfer_ff;
      logic [127:0] slot_bits;
      logic        take;
      logic        ack_tgl;

      assign link_en   = lnk_ctrl_ff[gd][LINK_EN_BIT];
      assign par_pack  = par_ctrl_ff[gd][PAR_PACK_BIT];
      assign lnk_agc   = lnk_ctrl_ff[gd][SRC_AGC_BIT];
      assign lnk_mode  = lnk_ctrl_ff[gd][LNK_MODE_BIT];
      // Exclusion bit matters only in AGC mode
      assign gain_incl = lnk_agc & ~lnk_ctrl_ff[gd][LNK_NOGAIN_BIT];
      assign slot_last = gain_incl ? 2'h0 : 2'h3;

      // Sources this side will queue under the current mode
      always_comb begin
        if (link_en) begin
          if (lnk_agc) begin
            accept[gd] = lnk_mode ? (6'h10 << gd) : 6'h30;
          end else begin
            accept[gd] = lnk_mode ? 6'h0F : 6'h03;
          end
        end else if (par_ctrl_ff[gd][SRC_AGC_BIT]) begin
          accept[gd] = {par_ctrl_ff[gd][AGC_B_EN_BIT],
                        par_ctrl_ff[gd][AGC_A_EN_BIT], 4'h0};
        end else begin
          accept[gd] = {2'b00, par_ctrl_ff[gd][CHAN_EN_LSB +: NUM_CHAN]};
        end
      end

      // Pending flags; a trigger in the clearing cycle wins over the clear
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          pend_ff[gd] <= 6'h00;
        end else begin
          pend_ff[gd] <= (pend_ff[gd] & ~(par_clr[gd] | lnk_clr[gd]))
                         | (src_trig & accept[gd]);
        end
      end

      // Lowest pending index wins when several wait
      always_comb begin
        pick    = 3'h0;
        pick_ok = 1'b0;
        for (int k = NUM_SRC - 1; k >= 0; k--) begin
          if (pend_ff[gd][k]) begin
            pick    = 3'(k);
            pick_ok = 1'b1;
          end
        end
      end

      // Parallel engine serves queued words only while the link is off
      assign par_clr[gd] = (!link_en && !pbusy_ff && pick_ok)
                           ? (6'h01 << pick) : 6'h00;
      assign par_busy[gd] = pbusy_ff;

      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          pbusy_ff          <= 1'b0;
          psel_ff           <= 3'h0;
          par_data_out[gd]  <= 16'h0000;
          par_valid_out[gd] <= 1'b0;
          par_iq_out[gd]    <= 1'b0;
          par_src_out[gd]   <= 3'h0;
        end else begin
          par_valid_out[gd] <= 1'b0;
          if (pbusy_ff) begin
            par_data_out[gd]  <= src_ff[psel_ff].q;
            par_iq_out[gd]    <= 1'b0;
            par_valid_out[gd] <= 1'b1;
            pbusy_ff          <= 1'b0;
          end else if (!link_en && pick_ok) begin
            par_src_out[gd]   <= pick;
            par_valid_out[gd] <= 1'b1;
            par_iq_out[gd]    <= 1'b1;
            psel_ff           <= pick;
            if (par_pack) begin
              par_data_out[gd] <= {src_ff[pick].i[15:8], src_ff[pick].q[15:8]};
            end else begin
              par_data_out[gd] <= src_ff[pick].i;
              pbusy_ff         <= 1'b1;
            end
          end
        end
      end

      // Source feeding the next link slot
      always_comb begin
        if (lnk_agc) begin
          lsrc = lnk_mode ? 3'(4 + gd) : {2'b10, seq_ff[0]};
        end else begin
          lsrc = lnk_mode ? {1'b0, seq_ff} : {2'b00, seq_ff[0]};
        end
      end

      // IQ in the slot; gain sits after IQ, the rest of the quad stays zero
      always_comb begin
        slot_bits = 128'(src_ff[lsrc].i) | (128'(src_ff[lsrc].q) << 16);
        slot_bits = slot_bits << {slot_ff, 5'h00};
        if (gain_incl) slot_bits = slot_bits | (128'(src_ff[lsrc].gain) << 32);
      end

      // Ack toggle back from the link domain, three stages, counted on agreement
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          ack_s_ff  <= 3'h0;
          ack_ok_ff <= 1'b0;
        end else begin
          ack_s_ff <= {ack_s_ff[1:0], ack_tgl};
          if (ack_s_ff[1] == ack_s_ff[2]) ack_ok_ff <= ack_s_ff[2];
        end
      end

      assign xfer_open[gd] = (req_ff != ack_ok_ff);
      // Building stalls while a quad is still owned by the link domain
      assign take = link_en && !xfer_open[gd] && pend_ff[gd][lsrc];
      assign lnk_clr[gd] = take ? (6'h01 << lsrc) : 6'h00;

      // Quad builder; held stable from the request toggle until the ack
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          slot_ff <= 2'h0;
          seq_ff  <= 2'h0;
          req_ff  <= 1'b0;
          xfer_ff <= '0;
        end else if (!link_en) begin
          slot_ff <= 2'h0;
          seq_ff  <= 2'h0;
        end else if (take) begin
          seq_ff       <= seq_ff + 2'h1;
          xfer_ff.data <= (slot_ff == 2'h0) ? slot_bits : (xfer_ff.data | slot_bits);
          xfer_ff.delay <= lnk_ctrl_ff[gd][DLY_LSB +: DLY_W];
          if (slot_ff == slot_last) begin
            slot_ff <= 2'h0;
            req_ff  <= ~req_ff;
          end else begin
            slot_ff <= slot_ff + 2'h1;
          end
        end
      end

      link_port_tx u_link (
        .link_clk_in (link_clk_in),
        .link_rst_in (link_rst_in),
        .xfer_in     (xfer_ff),
        .req_tgl_in  (req_ff),
        .ack_tgl_out (ack_tgl),
        .rdy_in      (link_rdy_in[gd]),
        .data_out    (link_data_out[gd]),
        .valid_out   (link_valid_out[gd])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ===== opr_chk.sv
// Port checker for the output routing block
`timescale 1ns/10ps
`default_nettype none
module opr_chk
  import output_routing_pkg::*;
(
  // Clocks and resets
  input  wire logic       clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       link_clk_in,
  input  wire logic       link_rst_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_rdata_out,
  // Output ports
  input  wire logic [1:0] par_valid_out,
  input  wire logic [1:0] par_iq_out,
  input  wire logic [1:0] link_rdy_in,
  input  wire logic [1:0] link_valid_out
);
  logic [7:0] pa_ff, pb_ff, la_ff, lb_ff;
  logic [4:0] run_ff;
  // Shadow copies of the control registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      {pa_ff, pb_ff, la_ff, lb_ff} <= '0;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        PAR_A_OFS: pa_ff <= reg_wdata_in;
        PAR_B_OFS: pb_ff <= reg_wdata_in;
        LNK_A_OFS: la_ff <= reg_wdata_in;
        LNK_B_OFS: lb_ff <= reg_wdata_in;
        default: ;
      endcase
    end
  end
  // Length of the current byte run on link A
  always_ff @(posedge link_clk_in) begin
    if (link_rst_in) run_ff <= 5'h00;
    else run_ff <= link_valid_out[0] ? run_ff + 5'h01 : 5'h00;
  end
  rdata_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00) else $error("read data not idle");
  par_a_excl_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_valid_out[0] |-> !la_ff[LINK_EN_BIT]) else $error("parallel A while link A on");
  par_b_excl_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_valid_out[1] |-> !lb_ff[LINK_EN_BIT]) else $error("parallel B while link B on");
  link_a_en_a: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    link_valid_out[0] |-> la_ff[LINK_EN_BIT]) else $error("link A sends while off");
  link_b_en_a: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    link_valid_out[1] |-> lb_ff[LINK_EN_BIT]) else $error("link B sends while off");
  i_then_q_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_valid_out[0] && par_iq_out[0] && !pa_ff[PAR_PACK_BIT] |=>
    par_valid_out[0] && !par_iq_out[0]) else $error("I word not followed by Q");
  packed_iq_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    par_valid_out[1] && pb_ff[PAR_PACK_BIT] |-> par_iq_out[1]) else $error("packed iq low");
  quad_len_a: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    $fell(link_valid_out[0]) |-> run_ff == 5'h10) else $error("link run not 16 bytes");
  rdy_wait_a: assert property (@(posedge link_clk_in) disable iff (link_rst_in)
    $rose(link_rdy_in[0]) |=> !link_valid_out[0] [*8]) else $error("link sent too early");
  // Main scenarios
  c_quad: cover property (@(posedge link_clk_in) $fell(link_valid_out[0]));
  c_pack: cover property (@(posedge clk_in) par_valid_out[1] && pb_ff[PAR_PACK_BIT]);
  c_pair: cover property (@(posedge clk_in) par_valid_out[0] ##1 par_valid_out[0]);
endmodule
bind output_port_routing_control opr_chk chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .link_clk_in(link_clk_in), .link_rst_in(link_rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .par_valid_out(par_valid_out), .par_iq_out(par_iq_out),
  .link_rdy_in(link_rdy_in), .link_valid_out(link_valid_out));
`default_nettype wire

// ===== link_rx_model.sv
// Receiver model for one link port: gives ready, gathers quad-words
`timescale 1ns/10ps
`default_nettype none
module link_rx_model (
  // Link clock domain
  input  wire logic         link_clk_in,
  input  wire logic         link_rst_in,
  // High stalls the receiver
  input  wire logic         hold_in,
  // Link pins
  input  wire logic         valid_in,
  input  wire logic [7:0]   data_in,
  output logic              rdy_out,
  // Gathered quad-words
  output logic [127:0]      quad_out,
  output logic [7:0]        n_quad_out
);
  logic [3:0]   cnt_ff;
  logic [119:0] shift_ff;
  // Byte 0 comes first and lands in the low byte
  always_ff @(posedge link_clk_in) begin
    if (link_rst_in) begin
      cnt_ff     <= 4'h0;
      n_quad_out <= 8'h00;
      quad_out   <= '0;
    end else if (valid_in) begin
      cnt_ff   <= cnt_ff + 4'h1;
      shift_ff <= {data_in, shift_ff[119:8]};
      if (cnt_ff == 4'hF) begin
        quad_out   <= {data_in, shift_ff};
        n_quad_out <= n_quad_out + 8'h01;
      end
    end
  end
  // Ready drops for one link clock after each quad, too short to pass the transmitter's agreeing synchroniser
  always_ff @(posedge link_clk_in) begin
    if (link_rst_in) rdy_out <= 1'b0;
    else rdy_out <= !hold_in && !(valid_in && cnt_ff == 4'hF);
  end
endmodule
`default_nettype wire

// ===== output_port_routing_control_bench.sv
// Self-checking bench for the output routing block
`timescale 1ns/10ps
`default_nettype none
module output_port_routing_control_bench
  import output_routing_pkg::*;
;
  logic         clk, rst, lclk, wr, rd;
  logic [7:0]   addr, wdata, rdata, v;
  src_word_t    cw [NUM_CHAN];
  src_word_t    aw [NUM_AGC];
  logic [3:0]   ctrig;
  logic [1:0]   atrig, pvalid, piq, lrdy, lvalid, hold;
  logic [15:0]  pdata [NUM_SIDE];
  logic [2:0]   psrc [NUM_SIDE];
  logic [7:0]   ldata [NUM_SIDE];
  logic [127:0] quad [NUM_SIDE];
  logic [7:0]   nq [NUM_SIDE];
  logic [19:0]  pq0 [$];
  logic [19:0]  pq1 [$];
  int           n_fail;
  int           comparisons;

  output_port_routing_control uut (.clk_in(clk), .sys_rst_in(rst), .link_clk_in(lclk),
    .link_rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .chan_word_in(cw), .chan_trig_in(ctrig),
    .agc_word_in(aw), .agc_trig_in(atrig), .par_data_out(pdata), .par_valid_out(pvalid),
    .par_iq_out(piq), .par_src_out(psrc), .link_rdy_in(lrdy), .link_data_out(ldata),
    .link_valid_out(lvalid));
  // One receiver per side
  link_rx_model rx0 (.link_clk_in(lclk), .link_rst_in(rst), .hold_in(hold[0]),
    .valid_in(lvalid[0]), .data_in(ldata[0]), .rdy_out(lrdy[0]), .quad_out(quad[0]),
    .n_quad_out(nq[0]));
  link_rx_model rx1 (.link_clk_in(lclk), .link_rst_in(rst), .hold_in(hold[1]),
    .valid_in(lvalid[1]), .data_in(ldata[1]), .rdy_out(lrdy[1]), .quad_out(quad[1]),
    .n_quad_out(nq[1]));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Link clock with an odd offset so the two never line up
  initial begin
    lclk = 1'b0;
    #13;
    forever #40 lclk = ~lclk;
  end
  // Parallel words as {iq, source, data}, registered outputs read at the edge
  always @(posedge clk) begin
    if (pvalid[0] === 1'b1) pq0.push_back({piq[0], psrc[0], pdata[0]});
    if (pvalid[1] === 1'b1) pq1.push_back({piq[1], psrc[1], pdata[1]});
  end

  task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic trig(input logic [3:0] c, input logic [1:0] a);
    @(posedge clk);
    ctrig <= c;
    atrig <= a;
    @(posedge clk);
    ctrig <= 4'h0;
    atrig <= 2'h0;
  endtask
  // Bounded wait for n parallel words, then a margin to catch extra words
  task automatic wait_par(input int side, input int n);
    for (int k = 0; k < 40 && (side ? pq1.size() : pq0.size()) < n; k++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_quad(input int side, input logic [7:0] old);
    for (int k = 0; k < 600 && nq[side] === old; k++) @(posedge clk);
  endtask

  task automatic t_regs();
    rd_reg(PAR_A_OFS, v);
    chk("par A reset", v, CTRL_RST);
    rd_reg(LNK_B_OFS, v);
    chk("link B reset", v, CTRL_RST);
    wr_reg(PAR_A_OFS, 8'hFF);
    rd_reg(PAR_A_OFS, v);
    chk("par A top bits", v, 8'h3F);
    wr_reg(LNK_A_OFS, 8'h25);
    rd_reg(LNK_A_OFS, v);
    chk("link A readback", v, 8'h25);
    rd_reg(8'h05, v);
    chk("unmapped read", v, RDATA_RST);
    rd_reg(STATUS_OFS, v);
    chk("status idle", v, 8'h00);
  endtask
  // Two enabled channels trigger together with a disabled one
  task automatic t_par();
    wr_reg(PAR_A_OFS, 8'h0C);
    trig(4'h7, 2'h0);
    wait_par(0, 4);
    chk("par count", 128'(pq0.size()), 128'h4);
    chk("ch1 I", 128'(pq0[0]), 128'({1'b1, 3'h1, cw[1].i}));
    chk("ch1 Q", 128'(pq0[1]), 128'({1'b0, 3'h1, cw[1].q}));
    chk("ch2 I", 128'(pq0[2]), 128'({1'b1, 3'h2, cw[2].i}));
    chk("ch2 Q", 128'(pq0[3]), 128'({1'b0, 3'h2, cw[2].q}));
  endtask
  task automatic t_pack();
    pq0.delete();
    wr_reg(PAR_B_OFS, 8'h25);
    trig(4'h0, 2'h3);
    wait_par(1, 1);
    chk("agc count", 128'(pq1.size()), 128'h1);
    chk("agc B packed", 128'(pq1[0]), 128'({1'b1, 3'h5, aw[1].i[15:8], aw[1].q[15:8]}));
    chk("A ignores agc", 128'(pq0.size()), 128'h0);
  endtask
  // Receiver stalls first, then four channels go out in one quad
  task automatic t_lchan();
    logic [7:0] old;
    old = nq[0];
    hold <= 2'b01;
    wr_reg(LNK_A_OFS, 8'hC2);
    trig(4'hF, 2'h0);
    repeat (30) @(posedge clk);
    hold <= 2'b00;
    wait_quad(0, old);
    chk("quad four chan", quad[0], {cw[3].q, cw[3].i, cw[2].q, cw[2].i,
      cw[1].q, cw[1].i, cw[0].q, cw[0].i});
    chk("par A silent", 128'(pq0.size()), 128'h0);
  endtask
  task automatic t_lagc();
    logic [7:0] old;
    old = nq[1];
    pq1.delete();
    wr_reg(LNK_B_OFS, 8'h83);
    trig(4'h0, 2'h3);
    wait_quad(1, old);
    chk("quad agc gain", quad[1], {80'h0, aw[1].gain, aw[1].q, aw[1].i});
    chk("par B silent", 128'(pq1.size()), 128'h0);
  endtask
  // Two-channel link A with the gain bit set, alternating AGCs on link B
  task automatic t_lalt();
    logic [7:0] o0;
    logic [7:0] o1;
    o0 = nq[0];
    o1 = nq[1];
    wr_reg(LNK_B_OFS, 8'h00);
    wr_reg(LNK_A_OFS, 8'h84);
    wr_reg(LNK_B_OFS, 8'h85);
    trig(4'h3, 2'h3);
    trig(4'h3, 2'h3);
    wait_quad(0, o0);
    wait_quad(1, o1);
    chk("quad two chan", quad[0], {2{cw[1].q, cw[1].i, cw[0].q, cw[0].i}});
    chk("quad agc alt", quad[1], {2{aw[1].q, aw[1].i, aw[0].q, aw[0].i}});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    #3000000;
    n_fail++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    {addr, wdata, wr, rd, ctrig, atrig, hold} = '0;
    for (int k = 0; k < NUM_CHAN; k++) cw[k] = {16'hA100 + 16'(k), 16'hB200 + 16'(k),
      16'hC300 + 16'(k)};
    for (int k = 0; k < NUM_AGC; k++) aw[k] = {16'hD400 + 16'(k), 16'hE500 + 16'(k),
      16'hF600 + 16'(k)};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_par();
    t_pack();
    t_lchan();
    t_lagc();
    t_lalt();
    give_verdict();
  end
endmodule
`default_nettype wire
